// ### verilog/hcd_defs.svh
// constants for the harvard core datapath
`ifndef HCD_DEFS_SVH
`define HCD_DEFS_SVH
// ----------------------------------------------------------------
// data memory map (special registers)
// ----------------------------------------------------------------
`define HCD_ADDR_INDF 7'h00
`define HCD_ADDR_PCL 7'h02
`define HCD_ADDR_STATUS 7'h03
`define HCD_ADDR_FSR 7'h04
`define HCD_ADDR_PCLATH 7'h0a
// ----------------------------------------------------------------
// status fields and reset values
// ----------------------------------------------------------------
`define HCD_ST_C 0
`define HCD_ST_DIGIT 1
`define HCD_ST_Z 2
`define HCD_RST_STATUS 8'h18
`define HCD_RST_PC 10'h000
`define HCD_NOP_WORD 14'h0000
// ----------------------------------------------------------------
// instruction fields
// ----------------------------------------------------------------
`define HCD_OP_HI 13
`define HCD_OP_LO 8
`define HCD_DEST_BIT 7
`define HCD_LIT_HI 7
`define HCD_FADDR_HI 6
`define HCD_BR_HI 10
`endif

// ### verilog/hcd_pkg.sv
// types for the harvard core datapath
package hcd_pkg;
	// arithmetic unit operation select
	typedef enum logic [3:0] {
		HCD_OP_PASS_B = 4'h0,
		HCD_OP_ADD = 4'h1,
		HCD_OP_SUB = 4'h2,
		HCD_OP_AND = 4'h3,
		HCD_OP_IOR = 4'h4,
		HCD_OP_XOR = 4'h5,
		HCD_OP_COM = 4'h6,
		HCD_OP_INC = 4'h7,
		HCD_OP_DEC = 4'h8,
		HCD_OP_RLF = 4'h9,
		HCD_OP_RRF = 4'ha,
		HCD_OP_SWAP = 4'hb,
		HCD_OP_CLR = 4'hc
	} hcd_aop_t;
	// flag triple carried with every result
	typedef struct packed {
		logic z;
		logic digit_carry_flag;
		logic c;
	} hcd_flags_t;
	// which flags an instruction may write
	typedef struct packed {
		logic z;
		logic digit_carry_flag;
		logic c;
	} hcd_fmask_t;
	// pipeline state
	typedef enum logic [0:0] {
		HCD_ST_RUN = 1'b0,
		HCD_ST_FLUSH = 1'b1
	} hcd_state_t;
endpackage

// ### verilog/hcd_arith_unit.sv
// 8-bit arithmetic unit with carry, digit-carry and zero out
`timescale 1ns/100ps
`include "hcd_defs.svh"
module hcd_arith_unit #(
	parameter int WIDTH = 8
) (
	// operands and select
	input wire logic [WIDTH-1:0] i_a,
	input wire logic [WIDTH-1:0] i_b,
	input wire hcd_pkg::hcd_aop_t i_op,
	input wire logic i_cin,
	// result and flags
	output logic [WIDTH-1:0] o_res,
	output hcd_pkg::hcd_flags_t o_flags
);
	import hcd_pkg::*;
	// elaboration check: nibble and flag logic are written for bytes only
	if (WIDTH != 8) begin
		$error("arith unit supports only 8 bits");
	end
	logic [WIDTH:0] sum;
	logic [4:0] nib;
	// one combinational result per operation
	always_comb begin
		sum = '0;
		nib = '0;
		o_res = '0;
		o_flags = '0;
		o_flags.c = i_cin;
		unique case (i_op)
			HCD_OP_ADD: begin
				sum = {1'b0, i_a} + {1'b0, i_b};
				nib = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
				o_res = sum[WIDTH-1:0];
				o_flags.c = sum[WIDTH];
				o_flags.digit_carry_flag = nib[4];
			end
			HCD_OP_SUB: begin
				// b minus a by adding the two's complement
				sum = {1'b0, i_b} + {1'b0, ~i_a} + 9'h001;
				nib = {1'b0, i_b[3:0]} + {1'b0, ~i_a[3:0]} + 5'h01;
				o_res = sum[WIDTH-1:0];
				o_flags.c = sum[WIDTH];
				o_flags.digit_carry_flag = nib[4];
			end
			HCD_OP_AND: o_res = i_a & i_b;
			HCD_OP_IOR: o_res = i_a | i_b;
			HCD_OP_XOR: o_res = i_a ^ i_b;
			HCD_OP_COM: o_res = ~i_b;
			HCD_OP_INC: o_res = i_b + 8'h01;
			HCD_OP_DEC: o_res = i_b - 8'h01;
			HCD_OP_RLF: begin
				o_res = {i_b[WIDTH-2:0], i_cin};
				o_flags.c = i_b[WIDTH-1];
			end
			HCD_OP_RRF: begin
				o_res = {i_cin, i_b[WIDTH-1:1]};
				o_flags.c = i_b[0];
			end
			HCD_OP_SWAP: o_res = {i_b[3:0], i_b[7:4]};
			HCD_OP_CLR: o_res = '0;
			default: o_res = i_b;
		endcase
		o_flags.z = (o_res == '0);
	end
endmodule

// ### verilog/hcd_core.sv
// harvard datapath: two-stage pipeline, working register, file
`timescale 1ns/100ps
`include "hcd_defs.svh"
module hcd_core #(
	parameter int PROG_WORDS = 1024,
	parameter int FILE_BYTES = 80
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// program memory bus
	output logic [9:0] o_prog_addr,
	input wire logic [13:0] i_prog_word,
	// observation
	output logic [7:0] o_work,
	output hcd_pkg::hcd_flags_t o_flags,
	output logic o_flush
);
	import hcd_pkg::*;
	// elaboration checks on sizes the address logic can serve
	if (PROG_WORDS != 512 && PROG_WORDS != 1024) begin
		$error("program size 512 or 1024");
	end
	if (FILE_BYTES < 16 || FILE_BYTES > 128) begin
		$error("file size 16..128");
	end
	localparam logic [9:0] PC_MASK = 10'(PROG_WORDS - 1);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [9:0] pc_reg;
	logic [13:0] ir_reg;
	logic [7:0] w_reg; // not in the data map
	logic [7:0] status_reg;
	logic [7:0] fsr_reg;
	logic [7:0] pclath_reg;
	logic [7:0] file_mem [FILE_BYTES];
	hcd_state_t state_reg;
	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic [5:0] opc;
	logic dest_f;
	logic [6:0] dir_addr;
	logic [6:0] eff_addr;
	logic [7:0] lit;
	hcd_aop_t aop;
	logic use_lit;
	logic wr_en;
	logic is_branch;
	hcd_fmask_t fmask;
	logic [7:0] fval;
	logic [7:0] arith_res;
	hcd_flags_t arith_fl;
	logic [7:0] a_opnd;
	logic [7:0] b_opnd;
	assign opc = ir_reg[`HCD_OP_HI:`HCD_OP_LO];
	assign dest_f = ir_reg[`HCD_DEST_BIT];
	assign dir_addr = ir_reg[`HCD_FADDR_HI:0];
	assign lit = ir_reg[`HCD_LIT_HI:0];
	// indirect through the pointer register
	assign eff_addr = (dir_addr == `HCD_ADDR_INDF) ? fsr_reg[6:0] : dir_addr;
	// operation decode, simplified byte-oriented map
	always_comb begin
		aop = HCD_OP_PASS_B;
		use_lit = 1'b0;
		wr_en = 1'b0;
		is_branch = 1'b0;
		fmask = '0;
		unique case (opc[5:4])
			2'b00: begin
				wr_en = 1'b1;
				fmask = '{z: 1'b1, digit_carry_flag: 1'b0, c: 1'b0};
				unique case (opc[3:0])
					4'h1: aop = HCD_OP_CLR;
					4'h2: begin aop = HCD_OP_SUB; fmask = 3'b111; end
					4'h3: aop = HCD_OP_DEC;
					4'h4: aop = HCD_OP_IOR;
					4'h5: aop = HCD_OP_AND;
					4'h6: aop = HCD_OP_XOR;
					4'h7: begin aop = HCD_OP_ADD; fmask = 3'b111; end
					4'h8: aop = HCD_OP_PASS_B;
					4'h9: aop = HCD_OP_COM;
					4'ha: aop = HCD_OP_INC;
					4'hc: begin aop = HCD_OP_RRF; fmask = 3'b001; end
					4'hd: begin aop = HCD_OP_RLF; fmask = 3'b001; end
					4'he: begin aop = HCD_OP_SWAP; fmask = '0; end
					default: begin wr_en = 1'b0; fmask = '0; end
				endcase
			end
			2'b10: is_branch = 1'b1;
			2'b11: begin
				use_lit = 1'b1;
				wr_en = 1'b1;
				fmask = 3'b100;
				unique case (opc[3:2])
					2'b00: begin aop = HCD_OP_PASS_B; fmask = '0; end
					2'b01: begin aop = HCD_OP_IOR; end
					2'b10: begin aop = (opc[1]) ? HCD_OP_ADD : HCD_OP_SUB; fmask = 3'b111; end
					2'b11: aop = (opc[1]) ? HCD_OP_XOR : HCD_OP_AND;
				endcase
			end
			default: ;
		endcase
	end
	// file read incl. special registers
	always_comb begin
		unique case (eff_addr)
			`HCD_ADDR_PCL: fval = pc_reg[7:0];
			`HCD_ADDR_STATUS: fval = status_reg;
			`HCD_ADDR_FSR: fval = fsr_reg;
			`HCD_ADDR_PCLATH: fval = pclath_reg;
			`HCD_ADDR_INDF: fval = 8'h00;
			// unused low addresses read zero, never an unwritten byte
			default: begin
				if (32'(eff_addr) < FILE_BYTES && eff_addr > `HCD_ADDR_PCLATH) begin
					fval = file_mem[eff_addr];
				end else begin
					fval = 8'h00;
				end
			end
		endcase
	end
	// working register paired with file or literal
	assign a_opnd = w_reg;
	assign b_opnd = use_lit ? lit : fval;
	hcd_arith_unit #(.WIDTH(8)) u_arith (
		.i_a(a_opnd),
		.i_b(b_opnd),
		.i_op(aop),
		.i_cin(status_reg[`HCD_ST_C]),
		.o_res(arith_res),
		.o_flags(arith_fl)
	);
	logic exec;
	logic wr_file;
	logic wr_w;
	logic pcl_wr;
	assign exec = (state_reg == HCD_ST_RUN);
	assign wr_file = exec && wr_en && !use_lit && dest_f;
	assign wr_w = exec && wr_en && (use_lit || !dest_f);
	assign pcl_wr = wr_file && (eff_addr == `HCD_ADDR_PCL);
	assign o_flush = (state_reg == HCD_ST_FLUSH);
	// ----------------------------------------------------------------
	// fetch: separate program bus each cycle
	// ----------------------------------------------------------------
	assign o_prog_addr = pc_reg;
	logic [9:0] br_target;
	assign br_target = {pclath_reg[4:3], 8'h00} | (10'(ir_reg[`HCD_BR_HI:0]) & PC_MASK);
	// counter wraps inside program space
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			pc_reg <= `HCD_RST_PC;
		end else if (exec && is_branch) begin
			pc_reg <= br_target & PC_MASK;
		end else if (pcl_wr) begin
			pc_reg <= {pclath_reg[1:0], arith_res} & PC_MASK;
		end else begin
			pc_reg <= (pc_reg + 10'h001) & PC_MASK;
		end
	end
	// instruction register: discard prefetched word on branch
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			ir_reg <= `HCD_NOP_WORD;
			state_reg <= HCD_ST_RUN;
		end else begin
			ir_reg <= i_prog_word;
			state_reg <= (exec && (is_branch || pcl_wr)) ? HCD_ST_FLUSH : HCD_ST_RUN;
		end
	end
	// working register
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			w_reg <= 8'h00;
		end else if (wr_w) begin
			w_reg <= arith_res;
		end
	end
	// status flags from the arithmetic unit
	// flag updates come last so they win over a plain write in the same cycle
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			status_reg <= `HCD_RST_STATUS;
		end else begin
			if (wr_file && eff_addr == `HCD_ADDR_STATUS) begin
				status_reg <= arith_res;
			end
			if (exec && wr_en) begin
				if (fmask.c) status_reg[`HCD_ST_C] <= arith_fl.c;
				if (fmask.digit_carry_flag) begin
					status_reg[`HCD_ST_DIGIT] <= arith_fl.digit_carry_flag;
				end
				if (fmask.z) status_reg[`HCD_ST_Z] <= arith_fl.z;
			end
		end
	end
	// pointer and upper-counter latch
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			fsr_reg <= 8'h00;
			pclath_reg <= 8'h00;
		end else begin
			if (wr_file && eff_addr == `HCD_ADDR_FSR) fsr_reg <= arith_res;
			if (wr_file && eff_addr == `HCD_ADDR_PCLATH) pclath_reg <= arith_res;
		end
	end
	// general file bytes; any operation, only addresses above PCLATH and below FILE_BYTES
	always_ff @(posedge i_sys_clk) begin
		if (wr_file && 32'(eff_addr) < FILE_BYTES && eff_addr > `HCD_ADDR_PCLATH) begin
			file_mem[eff_addr] <= arith_res;
		end
	end
	assign o_work = w_reg;
	assign o_flags = '{z: status_reg[`HCD_ST_Z],
		digit_carry_flag: status_reg[`HCD_ST_DIGIT],
		c: status_reg[`HCD_ST_C]};
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence br_seq;
		exec && is_branch;
	endsequence
	branch_flush_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		br_seq |=> o_flush ##1 !o_flush) else $error("branch not two cycles");
	pc_step_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		exec && !is_branch && !pcl_wr |=> pc_reg == (($past(pc_reg) + 10'h001) & PC_MASK))
		else $error("pc did not step");
	pc_range_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(pc_reg & ~PC_MASK) == 10'h000) else $error("pc outside program");
	// flag updates beat a status write, so these hold for every destination
	zero_set_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		exec && wr_en && fmask.z |=> o_flags.z == ($past(arith_res) == 8'h00))
		else $error("zero flag wrong");
	sub_borrow_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		exec && wr_en && aop == HCD_OP_SUB |=> o_flags.c == ($past(b_opnd) >= $past(w_reg)))
		else $error("borrow flag wrong");
	digit_borrow_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		exec && wr_en && aop == HCD_OP_SUB
		|=> o_flags.digit_carry_flag == ($past(b_opnd[3:0]) >= $past(w_reg[3:0])))
		else $error("digit borrow flag wrong");
	work_load_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		wr_w |=> o_work == $past(arith_res)) else $error("work reg not loaded");
	flush_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_flush |=> $stable(o_work)) else $error("flushed word executed");
	// every edge takes the word on the program bus while the data side works
	fetch_take_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		1'b1 |=> ir_reg == $past(i_prog_word)) else $error("fetched word not taken");
endmodule

// ### tb/hcd_prog_mem.sv
// program memory model that answers the core's fetch bus
`timescale 1ns/100ps
module hcd_prog_mem #(
	parameter int WORDS = 1024
) (
	// fetch port
	input wire logic [9:0] i_addr,
	output logic [13:0] o_word
);
	// ------------------------------------------------------------
	// storage, loaded by the bench before each program runs
	// ------------------------------------------------------------
	logic [13:0] mem [WORDS];

	// whole word in the same cycle; the index wraps so a stray pc never reads x
	assign o_word = mem[32'(i_addr) % WORDS];
endmodule

// ### tb/harvard_alu_datapath_test.sv
// self-checking bench for the harvard core datapath
`timescale 1ns/100ps
module harvard_alu_datapath_test;
	import hcd_pkg::*;
	// ------------------------------------------------------------
	// clock, reset and design hookup
	// ------------------------------------------------------------
	logic sys_clk;
	logic rst;
	logic [9:0] prog_addr;
	logic [13:0] prog_word;
	logic [7:0] work;
	hcd_flags_t flags;
	logic flush;
	int bad_count = 0;
	int n_compared = 0;
	int cycles = 0;

	hcd_core #(.PROG_WORDS(1024), .FILE_BYTES(80)) u_dut (
		.i_sys_clk(sys_clk),
		.i_rst(rst),
		.o_prog_addr(prog_addr),
		.i_prog_word(prog_word),
		.o_work(work),
		.o_flags(flags),
		.o_flush(flush)
	);

	hcd_prog_mem #(.WORDS(1024)) u_mem (
		.i_addr(prog_addr),
		.o_word(prog_word)
	);

	// 10 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// ------------------------------------------------------------
	// shared helpers
	// ------------------------------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic test_done;
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// hang guard: the whole run needs well under a hundred cycles per program
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			$display("Error at %0t: run did not finish", $time);
			test_done;
		end
	end

	// load a program (rest nops), reset, run len+3 edges, then judge
	task automatic run(input logic [13:0] prog[$], input logic [7:0] exp_w,
			input logic [2:0] exp_f, input logic [9:0] exp_addr, input int exp_flush);
		int nflush;
		nflush = 0;
		for (int i = 0; i < 1024; i++) begin
			u_mem.mem[i] = (i < prog.size()) ? prog[i] : 14'h0000;
		end
		@(posedge sys_clk);
		#1 rst = 1'b1;
		repeat (2) @(posedge sys_clk);
		#1 rst = 1'b0;
		check(16'(prog_addr), 16'h0000, "first fetch address");
		for (int i = 0; i < prog.size() + 3; i++) begin
			@(posedge sys_clk);
			#1;
			if (flush === 1'b1) begin
				nflush++;
			end
		end
		check(16'(work), 16'(exp_w), "working register");
		check(16'(flags), 16'(exp_f), "flags z dc c");
		check(16'(prog_addr), 16'(exp_addr), "program address");
		check(16'(nflush), 16'(exp_flush), "discarded fetches");
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic test_reset;
		check(16'(work), 16'h0000, "reset working register");
		check(16'(flags), 16'h0000, "reset flags");
		check(16'(prog_addr), 16'h0000, "reset address");
		check(16'(flush), 16'h0000, "reset flush");
		$display("test_reset done");
	endtask

	// literal add: digit carry alone, then wrap to zero with carry
	task automatic test_add;
		run('{14'h300f, 14'h3a01}, 8'h10, 3'b010, 10'd5, 0);
		run('{14'h3010, 14'h3af0}, 8'h00, 3'b101, 10'd5, 0);
		$display("test_add done");
	endtask

	// literal minus w: borrow, exact zero, nibble borrow only
	task automatic test_sub;
		run('{14'h3005, 14'h3803}, 8'hfe, 3'b000, 10'd5, 0);
		run('{14'h3005, 14'h3805}, 8'h00, 3'b111, 10'd5, 0);
		run('{14'h3001, 14'h3810}, 8'h0f, 3'b001, 10'd5, 0);
		$display("test_sub done");
	endtask

	// file byte built from w, pointer set up, read back through indirection
	task automatic test_file;
		run('{14'h305a, 14'h01a0, 14'h07a0, 14'h3020, 14'h0184, 14'h0784,
			14'h0800, 14'h0e00}, 8'ha5, 3'b000, 10'd11, 0);
		$display("test_file done");
	endtask

	// rotates through carry, then the three literal logic ops
	task automatic test_shift_logic;
		run('{14'h3081, 14'h01a1, 14'h07a1, 14'h0d21, 14'h0c21, 14'h340c,
			14'h3c3c, 14'h3e0c}, 8'h00, 3'b101, 10'd11, 0);
		$display("test_shift_logic done");
	endtask

	// jump over three adds: the prefetched one must be dropped
	task automatic test_branch;
		run('{14'h3001, 14'h2005, 14'h3a10, 14'h3a10, 14'h3a10, 14'h3a02},
			8'h03, 3'b000, 10'd11, 1);
		// jump to the last word: the counter wraps to zero and refetches the add before the run ends
		run('{14'h3a01, 14'h23ff}, 8'h01, 3'b000, 10'd1, 1);
		$display("test_branch done");
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		for (int i = 0; i < 1024; i++) begin
			u_mem.mem[i] = 14'h0000;
		end
		repeat (20) @(posedge sys_clk);
		#1;
		test_reset;
		test_add;
		test_sub;
		test_file;
		test_shift_logic;
		test_branch;
		test_done;
	end
endmodule
